// file: logic/ssdp_pkg.sv
// shared constants for the spi slave data path and its master end
package ssdp_pkg;
  localparam int SSDP_CHAR_W = 8; // bits per character
  localparam int SSDP_HALF_DIV = 3; // master clocks per sck half period
  localparam logic SSDP_SS_IDLE = 1'h1; // select line level between frames
  localparam logic SSDP_LINE_PULL = 1'h1; // miso level when nobody drives
  localparam logic SSDP_SCK_IDLE = 1'h0; // sck rest level, mode 0
  localparam logic SSDP_TGL_RST = 1'h0; // reset value of crossing toggles
  localparam logic SSDP_DRE_RST = 1'h1; // holding buffer starts empty
endpackage : ssdp_pkg

// file: logic/ssdp_link_if.sv
// serial link between the slave data path and its master
`timescale 1ns/1ps
interface ssdp_link_if;
  import ssdp_pkg::*;
  logic ss_n; // slave select, low during a transaction
  logic sck; // serial clock, made by the master
  logic mosi; // master to slave data
  logic miso_out; // slave drive value
  logic miso_oe; // slave drives miso while high
  logic miso; // resolved miso wire level
  // undriven line floats to the pull level
  assign miso = miso_oe ? miso_out : SSDP_LINE_PULL;
  modport device (
    input ss_n,
    input sck,
    input mosi,
    output miso_out,
    output miso_oe
  );
  modport master (
    output ss_n,
    output sck,
    output mosi,
    input miso
  );
endinterface : ssdp_link_if

// file: logic/ssdp_device.sv
// slave end: sck-clocked shifter plus bus-clock flags and receive buffer
//
// Contract
// - select high keeps slave idle, miso released
// - software writes data only while empty flag
// - select low: sample and shift per mode
// - holding moved to shifter sets empty flag
// - one character received per character sent
// - character enters two-deep buffer at last bit
// - select rising ends transaction, sets complete flag
// - write needs three sck before boundary load
// - late write resends previously received character
// - empty flag set three bus clocks later
// - master: last character out, nothing waiting, complete
// - software master raises select after transaction
// - master: last bit in sets receive complete
// - overflow bit sticky until written one
// - overflow bit clears when receiver disabled
// - immediate mode raises overflow at once
// - software drains buffer after immediate overflow
// - deferred mode carries overflow marker with data
// - marker at head: overflow, error, zero data
// - receiver disable flushes buffer, drops reception
`timescale 1ns/1ps
module ssdp_device
  import ssdp_pkg::*;
#(
  parameter int CHAR_W = SSDP_CHAR_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  ssdp_link_if.device link,
  input wire logic [CHAR_W-1:0] tx_data,
  input wire logic tx_write,
  output logic tx_holding_empty_flag,
  output logic [CHAR_W-1:0] rx_buffer_output,
  input wire logic rx_read,
  output logic receive_complete_flag,
  output logic transmit_complete_flag,
  input wire logic txc_clear,
  output logic rx_overflow_bit,
  output logic error_flag,
  input wire logic ovf_clear,
  input wire logic immediate_overflow_notify,
  input wire logic receiver_enable
);
  localparam int CNT_W = $clog2(CHAR_W); // bit counter width
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CHAR_W - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CHAR_W-1:0] WORD_ZERO = '0;

  // ---------------- link domain, clocked by sck ----------------
  logic link_rst_n; // frame reset: power reset or select high
  logic [CNT_W-1:0] bit_cnt_r; // bits taken in this character
  logic [CHAR_W-1:0] rx_sh_r; // incoming shifter
  logic [CHAR_W-1:0] rx_word_r; // last full character, held for bus
  logic rx_tgl_r; // flips once per received character
  logic [CHAR_W-1:0] tx_sh_r; // outgoing shifter
  logic tx_s1_r; // write toggle, first sync stage
  logic tx_s2_r; // write toggle, second sync stage
  logic ack_tgl_r; // flips when holding buffer is consumed
  logic tx_pend; // a written character waits for the boundary
  logic at_boundary; // next falling edge starts a character
  logic [CHAR_W-1:0] rx_word_nxt; // shifter with the bit now on mosi
  logic [CHAR_W-1:0] tx_load; // word loaded at the boundary
  // holding word lives on the bus clock, read here only while pending
  logic [CHAR_W-1:0] tx_holding_buffer_r; // stable while pending
  logic tx_holding_toggle_r; // flips on each accepted write

  // select high holds every frame register in reset
  assign link_rst_n = rst_n & ~link.ss_n;
  assign rx_word_nxt = {rx_sh_r[CHAR_W-2:0], link.mosi};
  assign at_boundary = (bit_cnt_r == CNT_ZERO);
  assign tx_pend = (tx_s2_r != ack_tgl_r);
  // no fresh write in time: echo the last received character
  assign tx_load = tx_pend ? tx_holding_buffer_r : rx_word_r;
  // miso released whenever select is high, no sck needed
  assign link.miso_oe = ~link.ss_n;
  assign link.miso_out = tx_sh_r[CHAR_W-1];

  // sample on rising sck, mode 0
  always_ff @(posedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= CNT_ZERO;
      rx_sh_r <= WORD_ZERO;
    end else begin
      bit_cnt_r <= (bit_cnt_r == LAST_BIT) ? CNT_ZERO : bit_cnt_r + 1'b1;
      rx_sh_r <= rx_word_nxt;
    end
  end

  // completed character and its event toggle survive the frame end
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_r <= WORD_ZERO;
      rx_tgl_r <= SSDP_TGL_RST;
    end else if (bit_cnt_r == LAST_BIT) begin
      rx_word_r <= rx_word_nxt;
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // write toggle crosses in on two sck edges; with the boundary this
  // is why a write needs up to three sck cycles to be picked up
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      tx_s1_r <= SSDP_TGL_RST;
      tx_s2_r <= SSDP_TGL_RST;
    end else begin
      tx_s1_r <= tx_holding_toggle_r;
      tx_s2_r <= tx_s1_r;
    end
  end

  // shift out on falling sck; the first character of a frame is the
  // reset pattern because no boundary load has happened yet
  always_ff @(negedge link.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_sh_r <= WORD_ZERO;
    end else if (at_boundary) begin
      tx_sh_r <= tx_load;
    end else begin
      tx_sh_r <= {tx_sh_r[CHAR_W-2:0], 1'b0};
    end
  end

  // acknowledge toggle tells the bus side the holding word is taken
  always_ff @(negedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl_r <= SSDP_TGL_RST;
    end else if (at_boundary && tx_pend && !link.ss_n) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // ---------------- bus domain, clocked by clock ----------------
  logic dre_r; // holding buffer empty
  logic ss_s1_r, ss_s2_r, ss_s3_r; // select sync and edge stage
  logic rx_s1_r, rx_s2_r, rx_s3_r; // receive toggle sync
  logic ack_s1_r, ack_s2_r, ack_s3_r; // acknowledge toggle sync
  logic txc_r; // transaction complete
  logic ovf_r; // overflow bit
  logic err_r; // error flag
  logic pend_ovf_r; // deferred overflow awaiting a buffer slot
  logic [CHAR_W-1:0] ent0_r, ent1_r; // buffer data, ent0 is oldest
  logic mk0_r, mk1_r; // overflow markers riding with entries
  logic v0_r, v1_r; // entry valid bits
  logic [CHAR_W-1:0] ent0_nxt, ent1_nxt;
  logic mk0_nxt, mk1_nxt, v0_nxt, v1_nxt;
  logic pend_ovf_nxt;
  logic write_ok, ss_rise, rx_evt, ack_evt, pop, space;
  logic push_mark, push_data, lost, ovf_set, push;
  logic [CHAR_W-1:0] push_word;

  assign write_ok = tx_write & dre_r;
  assign ss_rise = ss_s2_r & ~ss_s3_r;
  // reception finishing while disabled is dropped
  assign rx_evt = (rx_s2_r ^ rx_s3_r) & receiver_enable;
  assign ack_evt = ack_s2_r ^ ack_s3_r;
  assign pop = rx_read & v0_r;
  // a slot is free once the pop in this cycle is counted
  assign space = ~v1_r | pop;
  assign push_mark = pend_ovf_r & space;
  assign push_data = rx_evt & space & ~pend_ovf_r;
  assign lost = rx_evt & ~push_data;
  assign push = push_mark | push_data;
  // marker entries carry zero as their data
  assign push_word = push_mark ? WORD_ZERO : rx_word_r;
  assign pend_ovf_nxt = receiver_enable &
    ((pend_ovf_r & ~push_mark) | (lost & ~immediate_overflow_notify));
  // immediate mode flags the drop; deferred flags the marker at head
  assign ovf_set = (lost & immediate_overflow_notify) |
    (v0_nxt & mk0_nxt & ~(v0_r & mk0_r));

  // two-entry buffer: pop shifts down, push fills first free slot
  always_comb begin
    ent0_nxt = pop ? ent1_r : ent0_r;
    mk0_nxt = pop ? mk1_r : mk0_r;
    v0_nxt = pop ? v1_r : v0_r;
    ent1_nxt = ent1_r;
    mk1_nxt = mk1_r;
    v1_nxt = pop ? 1'b0 : v1_r;
    if (push && !v0_nxt) begin
      ent0_nxt = push_word;
      mk0_nxt = push_mark;
      v0_nxt = 1'b1;
    end else if (push) begin
      ent1_nxt = push_word;
      mk1_nxt = push_mark;
      v1_nxt = 1'b1;
    end
    if (!receiver_enable) begin
      v0_nxt = 1'b0;
      v1_nxt = 1'b0;
    end
  end

  // crossing stages; the second and third stages feed the edge detects
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {ss_s1_r, ss_s2_r, ss_s3_r} <= {3{SSDP_SS_IDLE}};
      {rx_s1_r, rx_s2_r, rx_s3_r} <= {3{SSDP_TGL_RST}};
      {ack_s1_r, ack_s2_r, ack_s3_r} <= {3{SSDP_TGL_RST}};
    end else if (clk_en) begin
      {ss_s1_r, ss_s2_r, ss_s3_r} <= {link.ss_n, ss_s1_r, ss_s2_r};
      {rx_s1_r, rx_s2_r, rx_s3_r} <= {rx_tgl_r, rx_s1_r, rx_s2_r};
      {ack_s1_r, ack_s2_r, ack_s3_r} <= {ack_tgl_r, ack_s1_r, ack_s2_r};
    end
  end

  // holding buffer and its empty flag; set lands three clocks after
  // the shifter takes the word, which is the crossing latency
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_buffer_r <= WORD_ZERO;
      tx_holding_toggle_r <= SSDP_TGL_RST;
      dre_r <= SSDP_DRE_RST;
    end else if (clk_en) begin
      if (write_ok) begin
        tx_holding_buffer_r <= tx_data;
        tx_holding_toggle_r <= ~tx_holding_toggle_r;
      end
      dre_r <= ack_evt | (dre_r & ~write_ok);
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txc_r <= 1'b0;
      ovf_r <= 1'b0;
      err_r <= 1'b0;
    end else if (clk_en) begin
      txc_r <= ss_rise | (txc_r & ~txc_clear);
      // disable clears outright, ahead of any set
      ovf_r <= receiver_enable & (ovf_set | (ovf_r & ~ovf_clear));
      err_r <= ovf_set | (err_r & ~ovf_clear);
    end
  end

  // receive buffer storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {ent0_r, ent1_r} <= {WORD_ZERO, WORD_ZERO};
      {mk0_r, mk1_r, v0_r, v1_r} <= 4'h0;
      pend_ovf_r <= 1'b0;
    end else if (clk_en) begin
      {ent0_r, ent1_r} <= {ent0_nxt, ent1_nxt};
      {mk0_r, mk1_r, v0_r, v1_r} <= {mk0_nxt, mk1_nxt, v0_nxt, v1_nxt};
      pend_ovf_r <= pend_ovf_nxt;
    end
  end

  assign tx_holding_empty_flag = dre_r;
  assign rx_buffer_output = ent0_r;
  assign receive_complete_flag = v0_r;
  assign transmit_complete_flag = txc_r;
  assign rx_overflow_bit = ovf_r;
  assign error_flag = err_r;
endmodule : ssdp_device

// file: logic/ssdp_master.sv
// master end: divides its clock to make sck and runs mode 0 frames
`timescale 1ns/1ps
module ssdp_master
  import ssdp_pkg::*;
#(
  parameter int CHAR_W = SSDP_CHAR_W,
  parameter int HALF_DIV = SSDP_HALF_DIV
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  ssdp_link_if.master link,
  input wire logic [CHAR_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_taken,
  output logic [CHAR_W-1:0] rx_data,
  output logic receive_complete_flag,
  output logic transmit_complete_flag,
  input wire logic hw_select_control_enable,
  input wire logic sw_select_n
);
  localparam int CNT_W = $clog2(CHAR_W);
  localparam int DIV_W = $clog2(HALF_DIV + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(CHAR_W - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} ssdp_mstate_t;
  ssdp_mstate_t st_r; // frame state
  logic [DIV_W-1:0] div_r; // half period divider
  logic [CNT_W-1:0] bit_r; // current bit
  logic [CHAR_W-1:0] tx_sh_r, rx_sh_r; // shifters
  logic sck_r, mosi_r, sel_r, ss_r; // pin drivers
  logic miso_s1_r, miso_s2_r; // miso synchroniser
  logic taken_r, rxc_r, txc_r; // user flags
  logic [CHAR_W-1:0] rx_data_r;
  logic half_done, last_bit;
  logic [CHAR_W-1:0] rx_next;

  // divider needs HALF_DIV of at least two so the synced miso is
  // settled before the sampling point
  assign half_done = (div_r == DIV_LAST);
  assign last_bit = (bit_r == LAST_BIT);
  assign rx_next = {rx_sh_r[CHAR_W-2:0], miso_s2_r};

  // miso arrives from the far end: two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      miso_s1_r <= SSDP_LINE_PULL;
      miso_s2_r <= SSDP_LINE_PULL;
    end else if (clk_en) begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // frame sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= M_IDLE;
      {div_r, bit_r} <= '0;
      {tx_sh_r, rx_sh_r, rx_data_r} <= '0;
      sck_r <= SSDP_SCK_IDLE;
      mosi_r <= 1'b0;
      sel_r <= SSDP_SS_IDLE;
      {taken_r, rxc_r, txc_r} <= 3'h0;
    end else if (clk_en) begin
      taken_r <= 1'b0;
      rxc_r <= 1'b0;
      div_r <= half_done ? '0 : div_r + 1'b1;
      unique case (st_r)
        M_IDLE: begin
          div_r <= '0;
          if (tx_valid) begin
            st_r <= M_LOW;
            sel_r <= ~SSDP_SS_IDLE;
            tx_sh_r <= {tx_data[CHAR_W-2:0], 1'b0};
            mosi_r <= tx_data[CHAR_W-1];
            bit_r <= '0;
            taken_r <= 1'b1;
            txc_r <= 1'b0;
          end
        end
        M_LOW: begin
          if (half_done) begin
            st_r <= M_HIGH;
            sck_r <= ~SSDP_SCK_IDLE;
          end
        end
        M_HIGH: begin
          if (half_done) begin
            sck_r <= SSDP_SCK_IDLE;
            rx_sh_r <= rx_next;
            st_r <= M_LOW;
            bit_r <= bit_r + 1'b1;
            mosi_r <= tx_sh_r[CHAR_W-1];
            tx_sh_r <= {tx_sh_r[CHAR_W-2:0], 1'b0};
            if (last_bit) begin
              rx_data_r <= rx_next;
              rxc_r <= 1'b1;
              bit_r <= '0;
              if (tx_valid) begin
                tx_sh_r <= {tx_data[CHAR_W-2:0], 1'b0};
                mosi_r <= tx_data[CHAR_W-1];
                taken_r <= 1'b1;
              end else begin
                st_r <= M_IDLE;
                txc_r <= 1'b1;
                sel_r <= SSDP_SS_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // select pin follows hardware control or the software level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ss_r <= SSDP_SS_IDLE;
    end else if (clk_en) begin
      ss_r <= hw_select_control_enable ? sel_r : sw_select_n;
    end
  end

  assign link.ss_n = ss_r;
  assign link.sck = sck_r;
  assign link.mosi = mosi_r;
  assign tx_taken = taken_r;
  assign rx_data = rx_data_r;
  assign receive_complete_flag = rxc_r;
  assign transmit_complete_flag = txc_r;
endmodule : ssdp_master

// file: tb/ssdp_link_sva.sv
// link checker for the slave data path and its master
`timescale 1ns/1ps
module ssdp_link_sva
  import ssdp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] rises_r; // sck rises seen in this frame
  // count rises so a frame can be judged for whole characters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rises_r <= 8'h00;
    else if (ss_n) rises_r <= 8'h00; // frame over, start afresh
    else if ($rose(sck)) rises_r <= rises_r + 8'h01;
  end
  AST_IDLE_RELEASE: assert property (
    ss_n |-> !miso_oe && miso == SSDP_LINE_PULL)
    else $error("miso driven while deselected");
  AST_SELECT_DRIVE: assert property (
    !ss_n |-> miso_oe)
    else $error("miso released while selected");
  AST_SCK_REST: assert property (
    ss_n && $past(ss_n) |-> sck == SSDP_SCK_IDLE)
    else $error("sck moved outside a frame");
  AST_FRAME_LEAD: assert property (
    $fell(ss_n) |-> !sck [*2])
    else $error("sck rose too soon after select");
  AST_SCK_HIGH: assert property (
    $rose(sck) |-> sck [*3] ##1 !sck)
    else $error("sck high phase has wrong length");
  AST_MOSI_HOLD: assert property (
    sck |-> $stable(mosi))
    else $error("mosi changed while sck high");
  AST_MISO_HOLD: assert property (
    sck && !ss_n |-> $stable(miso))
    else $error("miso changed while sck high");
  AST_WHOLE_CHARS: assert property (
    $rose(ss_n) |-> rises_r[2:0] == 3'h0 && rises_r != 8'h00)
    else $error("frame ended mid character");
  // main traffic shapes
  cover property ($fell(ss_n));
  cover property ($rose(ss_n));
  cover property ($rose(sck) && miso_oe);
  cover property (!ss_n && miso_out);
endmodule : ssdp_link_sva

// file: tb/tb.sv
// self-checking bench: master and slave ends joined by one link
`timescale 1ns/1ps
module tb;
  import ssdp_pkg::*;
  logic clock, rst_n;
  logic [7:0] d_txd, d_rx, m_txd, m_rx; // device and master data
  logic d_wr, d_rd, d_txcc, d_ovfc, d_imm, d_ren; // device controls
  logic d_dre, d_rxc, d_txc, d_ovf, d_err; // device flags
  logic m_val, m_tk, m_rxc, m_txc, m_hw, m_ssw; // master side
  logic [31:0] lfsr_r; // random source, fixed start
  logic [7:0] sq [$]; // characters sent by the master
  logic [7:0] mq [$]; // characters the master got back
  int fails, samples_checked, cyc;
  ssdp_link_if lnk();
  ssdp_device i_ssdp_device (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .link(lnk), .tx_data(d_txd), .tx_write(d_wr),
    .tx_holding_empty_flag(d_dre), .rx_buffer_output(d_rx),
    .rx_read(d_rd), .receive_complete_flag(d_rxc),
    .transmit_complete_flag(d_txc), .txc_clear(d_txcc),
    .rx_overflow_bit(d_ovf), .error_flag(d_err), .ovf_clear(d_ovfc),
    .immediate_overflow_notify(d_imm), .receiver_enable(d_ren));
  ssdp_master i_ssdp_master (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .link(lnk), .tx_data(m_txd), .tx_valid(m_val), .tx_taken(m_tk),
    .rx_data(m_rx), .receive_complete_flag(m_rxc),
    .transmit_complete_flag(m_txc), .hw_select_control_enable(m_hw),
    .sw_select_n(m_ssw));
  ssdp_link_sva u_sva (.clock(clock), .rst_n(rst_n), .ss_n(lnk.ss_n),
    .sck(lnk.sck), .mosi(lnk.mosi), .miso_out(lnk.miso_out),
    .miso_oe(lnk.miso_oe), .miso(lnk.miso));
  // bus clock, 100 ns period
  always #50 clock = ~clock;
  // collect what the master reads back
  always @(posedge clock) if (m_rxc === 1'b1) mq.push_back(m_rx);
  // hang guard; a full run needs well under two thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction : rnd
  // reply seen by the master at character k of a frame
  function automatic logic [7:0] reply(input int k, input bit wr,
    input logic [7:0] d, input logic [7:0] prev);
    if (k == 0) return 8'h00; // nothing preloaded
    if (k == 1 && wr) return d; // holding word loaded at boundary
    return prev; // late or missing write echoes last received
  endfunction : reply
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkb
  // optional holding write, then one frame of n random characters
  task automatic frame(input int n, input bit wr);
    logic [7:0] d;
    logic [7:0] s [$];
    int k;
    d = rnd();
    mq.delete();
    for (k = 0; k < n; k++) s.push_back(rnd());
    if (wr) begin
      @(posedge clock) d_txd <= d;
      d_wr <= 1'b1;
      @(posedge clock) d_wr <= 1'b0;
      @(negedge clock) chkb(d_dre, 1'b0);
    end
    @(posedge clock) m_txd <= s[0];
    m_val <= 1'b1;
    for (k = 0; k < n; k++) begin
      do @(negedge clock); while (m_tk !== 1'b1);
      chkb(m_txc, 1'b0);
      @(posedge clock);
      if (k + 1 < n) m_txd <= s[k+1];
      else m_val <= 1'b0; // last one taken, let the frame close
    end
    do @(negedge clock); while (m_txc !== 1'b1);
    @(posedge clock) m_ssw <= 1'b1;
    repeat (8) @(negedge clock);
    chk(8'(mq.size()), 8'(n));
    for (k = 0; k < n && k < mq.size(); k++)
      chk(mq[k], reply(k, wr, d, k > 0 ? s[k-1] : 8'h00));
    chkb(d_txc, 1'b1);
    chkb(d_dre, 1'b1);
    @(posedge clock) d_txcc <= 1'b1;
    @(posedge clock) d_txcc <= 1'b0;
    @(negedge clock) chkb(d_txc, 1'b0);
    sq = s;
  endtask : frame
  // pop the oldest received character after comparing it
  task automatic rd(input logic [7:0] e);
    do @(negedge clock); while (d_rxc !== 1'b1);
    chk(d_rx, e);
    @(posedge clock) d_rd <= 1'b1;
    @(posedge clock) d_rd <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : rd
  task automatic ovf_clr;
    @(posedge clock) d_ovfc <= 1'b1;
    @(posedge clock) d_ovfc <= 1'b0;
    @(negedge clock) chkb(d_ovf, 1'b0);
  endtask : ovf_clr
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    lfsr_r = 32'h0001_5c33;
    {d_txd, m_txd} = 16'h0000;
    {d_wr, d_rd, d_txcc, d_ovfc, m_val} = 5'h00;
    {d_imm, d_ren, m_hw, m_ssw} = 4'hf;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chkb(d_dre, SSDP_DRE_RST);
    chkb(d_rxc, 1'b0);
    @(posedge clock);
    // written holding word goes out second
    frame(2, 1);
    rd(sq[0]);
    rd(sq[1]);
    chkb(d_rxc, 1'b0);
    // software select, no write: echo of previous character
    @(posedge clock) m_hw <= 1'b0;
    m_ssw <= 1'b0;
    frame(2, 0);
    rd(sq[0]);
    rd(sq[1]);
    @(posedge clock) m_hw <= 1'b1;
    // immediate overflow: third character lost at once
    frame(3, 1);
    chkb(d_ovf, 1'b1);
    chkb(d_err, 1'b1);
    rd(sq[0]);
    rd(sq[1]);
    chkb(d_rxc, 1'b0);
    chkb(d_ovf, 1'b1);
    ovf_clr;
    chkb(d_err, 1'b0);
    // deferred overflow: marker travels behind the data
    @(posedge clock) d_imm <= 1'b0;
    frame(3, 0);
    chkb(d_ovf, 1'b0);
    rd(sq[0]);
    rd(sq[1]);
    rd(8'h00);
    chkb(d_ovf, 1'b1);
    chkb(d_err, 1'b1);
    ovf_clr;
    // receiver disable flushes buffer and overflow
    @(posedge clock) d_imm <= 1'b1;
    frame(3, 0);
    chkb(d_ovf, 1'b1);
    @(posedge clock) d_ren <= 1'b0;
    repeat (4) @(negedge clock);
    chkb(d_rxc, 1'b0);
    chkb(d_ovf, 1'b0);
    @(posedge clock) d_ren <= 1'b1;
    end_of_test;
  end
endmodule : tb
